/* pcg_pkg.sv */
// constants for the port crossbar and general-purpose port block
`default_nettype none
package pcg_pkg;
	// port geometry
	localparam int          PIN_COUNT       = 8;
	localparam int          SKIP_BITS       = 7;
	// register addresses on the special-function register port
	localparam logic [7:0]  ADDR_PORT_DATA  = 8'h80;
	localparam logic [7:0]  ADDR_OUT_MODE   = 8'hA4;
	localparam logic [7:0]  ADDR_SKIP       = 8'hE1;
	localparam logic [7:0]  ADDR_ROUTE      = 8'hE2;
	localparam logic [7:0]  ADDR_IN_MODE    = 8'hF1;
	localparam logic [7:0]  ADDR_GLOBAL     = 8'hF3;
	// reset values
	localparam logic [7:0]  RST_PORT_DATA   = 8'hFF;
	localparam logic [7:0]  RST_OUT_MODE    = 8'h00;
	localparam logic [7:0]  RST_IN_MODE     = 8'hFF;
	localparam logic [7:0]  RST_ROUTE       = 8'h00;
	localparam logic [7:0]  RST_GLOBAL      = 8'h00;
	localparam logic [6:0]  RST_SKIP        = 7'h00;
	// writable bits of the global control register
	localparam logic [7:0]  GLOBAL_WMASK    = 8'hC7;
	// field positions of the route select register
	localparam int          RT_CNT_HI       = 7;
	localparam int          RT_CNT_LO       = 6;
	localparam int          RT_CP_ASYNC     = 5;
	localparam int          RT_CP_SYNC      = 4;
	localparam int          RT_CLK_OUT      = 3;
	localparam int          RT_TWO_WIRE     = 2;
	localparam int          RT_SER_RX       = 1;
	localparam int          RT_SER_TX       = 0;
	// field positions of the global control register
	localparam int          GC_PULLUP_DIS   = 7;
	localparam int          GC_XBAR_EN      = 6;
	localparam int          GC_TIMER1       = 2;
	localparam int          GC_TIMER0       = 1;
	localparam int          GC_CNT_IN       = 0;
	// fixed pins of the serial port
	localparam logic [2:0]  PIN_SER_TX      = 3'h4;
	localparam logic [2:0]  PIN_SER_RX      = 3'h5;
	// pin function codes, in crossbar priority order
	localparam logic [3:0]  FN_NONE         = 4'h0;
	localparam logic [3:0]  FN_SER_TX       = 4'h1;
	localparam logic [3:0]  FN_SER_RX       = 4'h2;
	localparam logic [3:0]  FN_TW_DATA      = 4'h3;
	localparam logic [3:0]  FN_TW_CLK       = 4'h4;
	localparam logic [3:0]  FN_CMP_SYNC     = 4'h5;
	localparam logic [3:0]  FN_CMP_ASYNC    = 4'h6;
	localparam logic [3:0]  FN_CLK_OUT      = 4'h7;
	localparam logic [3:0]  FN_COUNTER_MODULE0_LINE         = 4'h8;
	localparam logic [3:0]  FN_CEX1         = 4'h9;
	localparam logic [3:0]  FN_CEX2         = 4'hA;
	localparam logic [3:0]  FN_CNT_IN       = 4'hB;
	localparam logic [3:0]  FN_TMR0_IN      = 4'hC;
	localparam logic [3:0]  FN_TMR1_IN      = 4'hD;
	localparam int          FN_COUNT        = 14;
	// result of a free-pin search that found none
	localparam logic [3:0]  PIN_NONE        = 4'h8;
endpackage
`default_nettype wire

/* pcg_crossbar.sv */
// port crossbar, port latch, pin modes and register port
`timescale 1ns/1ps
`default_nettype none
module pcg_crossbar (
	// clock and reset
	input  wire logic                   sys_clk,
	input  wire logic                   arst_n,
	// special-function register port
	input  wire logic [7:0]             sfr_addr,
	input  wire logic                   sfr_wr,
	input  wire logic [7:0]             sfr_wdata,
	input  wire logic                   sfr_bit_wr,
	input  wire logic [2:0]             sfr_bit_idx,
	input  wire logic                   sfr_bit_val,
	input  wire logic                   sfr_rd,
	input  wire logic                   sfr_rmw,
	output logic      [7:0]             sfr_rdata,
	output logic                        sfr_hit,
	// port pins
	input  wire logic [pcg_pkg::PIN_COUNT-1:0] pin_in,
	output logic      [pcg_pkg::PIN_COUNT-1:0] pin_out,
	output logic      [pcg_pkg::PIN_COUNT-1:0] pin_oe,
	output logic      [pcg_pkg::PIN_COUNT-1:0] pin_pullup_en,
	output logic      [pcg_pkg::PIN_COUNT-1:0] pin_analog,
	// signals from internal peripherals
	input  wire logic                   serial_transmit_line,
	input  wire logic                   two_wire_data_out,
	input  wire logic                   two_wire_clock_out,
	input  wire logic                   comparator_output,
	input  wire logic                   comparator_output_async,
	input  wire logic                   inverted_clock_output,
	input  wire logic [2:0]             counter_module_lines,
	// signals to internal peripherals
	output logic                        serial_receive_line,
	output logic                        two_wire_data_in,
	output logic                        two_wire_clock_in,
	output logic                        counter_external_input,
	output logic                        timer0_input,
	output logic                        timer1_input
);
	import pcg_pkg::*;

	typedef struct packed {
		logic [SKIP_BITS-1:0] pin_skip_bits;
		logic [7:0]           peripheral_route_select;
		logic [7:0]           crossbar_global_control;
		logic [7:0]           port_input_mode;
		logic [7:0]           port_output_mode;
		logic [7:0]           port_data_latch;
		logic [7:0]           pin_meta;
		logic [7:0]           pin_sync;
		logic [7:0]           rdata;
		logic                 hit;
		logic [7:0]           drv_out;
		logic [7:0]           drv_oe;
		logic [7:0]           drv_pu;
		logic [7:0]           drv_ana;
		logic                 rx_in;
		logic                 twd_in;
		logic                 twc_in;
		logic                 eci_in;
		logic                 t0_in;
		logic                 t1_in;
	} pcg_state_t;

	localparam pcg_state_t STATE_RESET = '{
		pin_skip_bits:           RST_SKIP,
		peripheral_route_select: RST_ROUTE,
		crossbar_global_control: RST_GLOBAL,
		port_input_mode:         RST_IN_MODE,
		port_output_mode:        RST_OUT_MODE,
		port_data_latch:         RST_PORT_DATA,
		pin_meta:                8'hFF,
		pin_sync:                8'hFF,
		rdata:                   8'h00,
		hit:                     1'b0,
		drv_out:                 8'hFF,
		drv_oe:                  8'h00,
		drv_pu:                  8'h00,
		drv_ana:                 8'h00,
		rx_in:                   1'b1,
		twd_in:                  1'b1,
		twc_in:                  1'b1,
		eci_in:                  1'b1,
		t0_in:                   1'b1,
		t1_in:                   1'b1
	};

	pcg_state_t st;
	pcg_state_t next_st;

	// lowest pin not yet taken; PIN_NONE when all are taken
	function automatic logic [3:0] first_free(input logic [7:0] used);
		logic [3:0] idx;
		idx = PIN_NONE;
		for (int p = PIN_COUNT - 1; p >= 0; p--) begin
			if (!used[p]) begin
				idx = 4'(p);
			end
		end
		return idx;
	endfunction

	// true when the address names a register of this block
	function automatic logic is_mapped(input logic [7:0] a);
		return (a == ADDR_PORT_DATA) || (a == ADDR_OUT_MODE) || (a == ADDR_SKIP) ||
			(a == ADDR_ROUTE) || (a == ADDR_IN_MODE) || (a == ADDR_GLOBAL);
	endfunction

	always_comb begin
		logic [FN_COUNT-1:0] want;
		logic [7:0]          used;
		logic [3:0]          func [PIN_COUNT];
		logic [3:0]          slot;
		logic [7:0]          level;
		logic                xbar_on;
		logic                val;
		logic                od_force;
		logic                push_pull;
		logic [1:0]          cnt_lines;

		next_st   = st;
		want      = '0;
		used      = '0;
		slot      = PIN_NONE;
		val       = 1'b1;
		od_force  = 1'b0;
		push_pull = 1'b0;
		level     = '1;
		xbar_on   = 1'b0;
		cnt_lines = 2'h0;
		for (int p = 0; p < PIN_COUNT; p++) begin
			func[p] = FN_NONE;
		end

		// input synchroniser; only the second stage is looked at
		next_st.pin_meta = pin_in;
		next_st.pin_sync = st.pin_meta;

		xbar_on   = st.crossbar_global_control[GC_XBAR_EN];
		cnt_lines = st.peripheral_route_select[RT_CNT_HI:RT_CNT_LO];

		// resource requests, indexed by function code
		want[FN_SER_TX]     = st.peripheral_route_select[RT_SER_TX];
		want[FN_SER_RX]     = st.peripheral_route_select[RT_SER_RX];
		want[FN_TW_DATA]    = st.peripheral_route_select[RT_TWO_WIRE];
		want[FN_TW_CLK]     = st.peripheral_route_select[RT_TWO_WIRE];
		want[FN_CMP_SYNC]   = st.peripheral_route_select[RT_CP_SYNC];
		want[FN_CMP_ASYNC]  = st.peripheral_route_select[RT_CP_ASYNC];
		want[FN_CLK_OUT]    = st.peripheral_route_select[RT_CLK_OUT];
		want[FN_COUNTER_MODULE0_LINE]       = (cnt_lines != 2'h0);
		want[FN_CEX1]       = (cnt_lines[1] == 1'b1);
		want[FN_CEX2]       = (cnt_lines == 2'h3);
		want[FN_CNT_IN]     = st.crossbar_global_control[GC_CNT_IN];
		want[FN_TMR0_IN]    = st.crossbar_global_control[GC_TIMER0];
		want[FN_TMR1_IN]    = st.crossbar_global_control[GC_TIMER1];

		// skipped pins count as already taken; pin 7 cannot be skipped
		used[SKIP_BITS-1:0] = st.pin_skip_bits;

		// serial lines sit on their fixed pins
		if (want[FN_SER_TX]) begin
			func[PIN_SER_TX] = FN_SER_TX;
			used[PIN_SER_TX] = 1'b1;
		end
		if (want[FN_SER_RX]) begin
			func[PIN_SER_RX] = FN_SER_RX;
			used[PIN_SER_RX] = 1'b1;
		end

		// the rest take the lowest free pin in code order
		for (int f = int'(FN_TW_DATA); f < FN_COUNT; f++) begin
			if (want[f]) begin
				slot = first_free(used);
				if (!slot[3]) begin
					func[slot[2:0]]  = 4'(f);
					used[slot[2:0]] = 1'b1;
				end
			end
		end

		// analog pins present a one to every reader
		level = st.pin_sync | ~st.port_input_mode;

		// pin drivers
		for (int p = 0; p < PIN_COUNT; p++) begin
			od_force = 1'b0;
			if (!xbar_on) begin
				val = st.port_data_latch[p];
			end else begin
				case (func[p])
					FN_NONE:      val = st.port_data_latch[p];
					FN_SER_TX:    val = serial_transmit_line;
					FN_TW_DATA: begin
						val      = two_wire_data_out;
						od_force = 1'b1;
					end
					FN_TW_CLK: begin
						val      = two_wire_clock_out;
						od_force = 1'b1;
					end
					FN_CMP_SYNC:  val = comparator_output;
					FN_CMP_ASYNC: val = comparator_output_async;
					FN_CLK_OUT:   val = inverted_clock_output;
					FN_COUNTER_MODULE0_LINE:      val = counter_module_lines[0];
					FN_CEX1:      val = counter_module_lines[1];
					FN_CEX2:      val = counter_module_lines[2];
					default:      val = 1'b1;
				endcase
			end
			push_pull = st.port_output_mode[p] && !od_force;
			next_st.drv_ana[p] = !st.port_input_mode[p];
			next_st.drv_out[p] = val;
			if (!xbar_on || !st.port_input_mode[p]) begin
				next_st.drv_oe[p] = 1'b0;
			end else begin
				next_st.drv_oe[p] = push_pull || !val;
			end
			next_st.drv_pu[p] = st.port_input_mode[p] &&
				!st.crossbar_global_control[GC_PULLUP_DIS] &&
				!(xbar_on && push_pull) &&
				!(xbar_on && !val);
		end

		// peripheral inputs idle high unless routed
		next_st.rx_in  = 1'b1;
		next_st.twd_in = 1'b1;
		next_st.twc_in = 1'b1;
		next_st.eci_in = 1'b1;
		next_st.t0_in  = 1'b1;
		next_st.t1_in  = 1'b1;
		if (xbar_on) begin
			for (int p = 0; p < PIN_COUNT; p++) begin
				case (func[p])
					FN_SER_RX:  next_st.rx_in  = level[p];
					FN_TW_DATA: next_st.twd_in = level[p];
					FN_TW_CLK:  next_st.twc_in = level[p];
					FN_CNT_IN:  next_st.eci_in = level[p];
					FN_TMR0_IN: next_st.t0_in  = level[p];
					FN_TMR1_IN: next_st.t1_in  = level[p];
					default:    ;
				endcase
			end
		end

		// register writes
		if (sfr_wr) begin
			case (sfr_addr)
				ADDR_PORT_DATA: next_st.port_data_latch = sfr_wdata;
				ADDR_OUT_MODE:  next_st.port_output_mode = sfr_wdata;
				ADDR_IN_MODE:   next_st.port_input_mode = sfr_wdata;
				ADDR_SKIP:      next_st.pin_skip_bits = sfr_wdata[SKIP_BITS-1:0];
				ADDR_ROUTE:     next_st.peripheral_route_select = sfr_wdata;
				ADDR_GLOBAL:    next_st.crossbar_global_control = sfr_wdata & GLOBAL_WMASK;
				default:        ;
			endcase
		end else if (sfr_bit_wr && sfr_addr == ADDR_PORT_DATA) begin
			next_st.port_data_latch[sfr_bit_idx] = sfr_bit_val;
		end

		// register reads, answered one cycle later
		next_st.hit = sfr_rd && is_mapped(sfr_addr);
		if (sfr_rd) begin
			case (sfr_addr)
				ADDR_PORT_DATA: begin
					if (sfr_rmw) begin
						next_st.rdata = st.port_data_latch;
					end else begin
						next_st.rdata = level;
					end
				end
				ADDR_OUT_MODE:  next_st.rdata = st.port_output_mode;
				ADDR_IN_MODE:   next_st.rdata = st.port_input_mode;
				ADDR_SKIP:      next_st.rdata = {1'b0, st.pin_skip_bits};
				ADDR_ROUTE:     next_st.rdata = st.peripheral_route_select;
				ADDR_GLOBAL:    next_st.rdata = st.crossbar_global_control;
				default:        next_st.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st <= STATE_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign sfr_rdata              = st.rdata;
	assign sfr_hit                = st.hit;
	assign pin_out                = st.drv_out;
	assign pin_oe                 = st.drv_oe;
	assign pin_pullup_en          = st.drv_pu;
	assign pin_analog             = st.drv_ana;
	assign serial_receive_line    = st.rx_in;
	assign two_wire_data_in       = st.twd_in;
	assign two_wire_clock_in      = st.twc_in;
	assign counter_external_input = st.eci_in;
	assign timer0_input           = st.t0_in;
	assign timer1_input           = st.t1_in;
endmodule
`default_nettype wire

/* pcg_pin_model.sv */
// far-side model: board drive on the port pins
`timescale 1ns/1ps
`default_nettype none
module pcg_pin_model (
	// device drive
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	// board level on released pins
	input  wire logic [7:0] ext_lvl,
	// level seen by the device
	output logic      [7:0] pin_in
);
	// a driving device pin wins over the board
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule
`default_nettype wire

/* pcg_crossbar_properties.sv */
// concurrent checks on the crossbar ports
`timescale 1ns/1ps
`default_nettype none
module pcg_crossbar_properties
	import pcg_pkg::*;
(
	// clock and reset
	input wire logic       sys_clk,
	input wire logic       arst_n,
	// register port
	input wire logic [7:0] sfr_addr,
	input wire logic       sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic       sfr_bit_wr,
	input wire logic [2:0] sfr_bit_idx,
	input wire logic       sfr_bit_val,
	input wire logic       sfr_rd,
	input wire logic       sfr_rmw,
	input wire logic [7:0] sfr_rdata,
	input wire logic       sfr_hit,
	// pins and peripheral inputs
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] pin_pullup_en,
	input wire logic [7:0] pin_analog,
	input wire logic       timer0_input,
	input wire logic       timer1_input
);
	// shadow registers tracked from the write strobes
	logic [7:0] latch_q;
	logic [7:0] in_q;
	logic [7:0] glob_q;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			latch_q <= 8'hFF;
			in_q <= 8'hFF;
			glob_q <= 8'h00;
		end else if (sfr_wr) begin
			case (sfr_addr)
				ADDR_PORT_DATA: latch_q <= sfr_wdata;
				ADDR_IN_MODE: in_q <= sfr_wdata;
				ADDR_GLOBAL: glob_q <= sfr_wdata;
				default: ;
			endcase
		end else if (sfr_bit_wr && sfr_addr == ADDR_PORT_DATA) begin
			latch_q[sfr_bit_idx] <= sfr_bit_val;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	a_skip_top_zero: assert property (sfr_rd && sfr_addr == ADDR_SKIP |=> sfr_hit && !sfr_rdata[7])
		else $error("skip top bit not zero");
	a_global_gaps_zero: assert property (sfr_rd && sfr_addr == ADDR_GLOBAL |=> sfr_rdata[5:3] == 3'h0)
		else $error("global unused bits not zero");
	a_rmw_reads_latch: assert property (sfr_rd && sfr_rmw && sfr_addr == ADDR_PORT_DATA
		|=> sfr_rdata == $past(latch_q))
		else $error("rmw read not latch");
	a_xbar_off_quiet: assert property (!glob_q[GC_XBAR_EN] |=> pin_oe == 8'h00)
		else $error("pin driven while crossbar off");
	a_off_inputs_idle: assert property (!glob_q[GC_XBAR_EN] [*3] |-> timer0_input && timer1_input)
		else $error("timer input not idle");
	a_analog_follow: assert property (pin_analog == ~$past(in_q))
		else $error("analog mode wrong");
	a_analog_quiet: assert property ((pin_analog & (pin_oe | pin_pullup_en)) == 8'h00)
		else $error("analog pin active");
	a_od_low_nopull: assert property ((pin_oe & ~pin_out & pin_pullup_en) == 8'h00)
		else $error("pull-up on while low");
	a_pullup_disabled: assert property (glob_q[GC_PULLUP_DIS] |=> pin_pullup_en == 8'h00)
		else $error("pull-up while disabled");
endmodule
bind pcg_crossbar pcg_crossbar_properties i_props (.sys_clk, .arst_n, .sfr_addr, .sfr_wr,
	.sfr_wdata, .sfr_bit_wr, .sfr_bit_idx, .sfr_bit_val, .sfr_rd, .sfr_rmw, .sfr_rdata,
	.sfr_hit, .pin_out, .pin_oe, .pin_pullup_en, .pin_analog, .timer0_input, .timer1_input);
`default_nettype wire

/* pcg_crossbar_test.sv */
// self-checking bench for the port crossbar
`timescale 1ns/1ps
`default_nettype none
module pcg_crossbar_test;
	import pcg_pkg::*;
	logic       sys_clk = 1'b0;
	logic       arst_n = 1'b0;
	logic [7:0] sfr_addr = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	logic       sfr_wr = 1'b0;
	logic       sfr_bit_wr = 1'b0;
	logic [2:0] sfr_bit_idx = 3'h0;
	logic       sfr_bit_val = 1'b0;
	logic       sfr_rd = 1'b0;
	logic       sfr_rmw = 1'b0;
	logic [7:0] ext_lvl = 8'hFF;
	logic [8:0] src = 9'h000;
	logic [7:0] sfr_rdata, pin_in, pin_out, pin_oe, pin_pullup_en, pin_analog;
	wire  [5:0] to_p;
	logic       sfr_hit, h;
	logic [7:0] d, rt, gc, sk, lat;
	int         error_cnt = 0;
	int         samples_checked = 0;
	integer     seed = 32'h84b7;
	logic [7:0] ra [7] = '{ADDR_PORT_DATA, ADDR_OUT_MODE, ADDR_SKIP, ADDR_ROUTE,
		ADDR_IN_MODE, ADDR_GLOBAL, 8'h55};
	logic [7:0] rv [7] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00};
	logic [7:0] wv [7] = '{8'h00, 8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'hC7, 8'h00};
	pcg_crossbar i_dut (
		.sys_clk, .arst_n, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_bit_wr, .sfr_bit_idx,
		.sfr_bit_val, .sfr_rd, .sfr_rmw, .sfr_rdata, .sfr_hit, .pin_in, .pin_out,
		.pin_oe, .pin_pullup_en, .pin_analog,
		.serial_transmit_line(src[8]), .two_wire_data_out(src[7]),
		.two_wire_clock_out(src[6]), .comparator_output(src[5]),
		.comparator_output_async(src[4]), .inverted_clock_output(src[3]),
		.counter_module_lines(src[2:0]), .serial_receive_line(to_p[0]),
		.two_wire_data_in(to_p[1]), .two_wire_clock_in(to_p[2]),
		.counter_external_input(to_p[3]), .timer0_input(to_p[4]), .timer1_input(to_p[5]));
	pcg_pin_model i_pins (.pin_out, .pin_oe, .ext_lvl, .pin_in);
	always #4 sys_clk = ~sys_clk;
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		if (error_cnt == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		#1 sfr_addr = a;
		sfr_wdata = v;
		sfr_wr = 1'b1;
		@(posedge sys_clk);
		#1 sfr_wr = 1'b0;
	endtask
	task automatic bwr(input logic [2:0] i, input logic v);
		@(posedge sys_clk);
		#1 sfr_addr = ADDR_PORT_DATA;
		sfr_bit_idx = i;
		sfr_bit_val = v;
		sfr_bit_wr = 1'b1;
		@(posedge sys_clk);
		#1 sfr_bit_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic m);
		@(posedge sys_clk);
		#1 sfr_addr = a;
		sfr_rmw = m;
		sfr_rd = 1'b1;
		@(posedge sys_clk);
		#1 sfr_rd = 1'b0;
		d = sfr_rdata;
		h = sfr_hit;
	endtask
	// lowest free pin per resource in priority order; serial keeps its pins
	function automatic void place(input logic [7:0] r, g, s, output logic [3:0] fn [8]);
		logic [7:0] used;
		logic [3:0] want [$];
		used = {1'b0, s[6:0]} | {2'b0, r[1:0], 4'h0};
		for (int p = 0; p < 8; p++) fn[p] = FN_NONE;
		fn[4] = r[RT_SER_TX] ? FN_SER_TX : FN_NONE;
		fn[5] = r[RT_SER_RX] ? FN_SER_RX : FN_NONE;
		if (r[RT_TWO_WIRE]) want = {FN_TW_DATA, FN_TW_CLK};
		if (r[RT_CP_SYNC]) want.push_back(FN_CMP_SYNC);
		if (r[RT_CP_ASYNC]) want.push_back(FN_CMP_ASYNC);
		if (r[RT_CLK_OUT]) want.push_back(FN_CLK_OUT);
		for (int k = 0; k < int'(r[7:6]); k++) want.push_back(4'(FN_COUNTER_MODULE0_LINE + k));
		for (int k = 0; k < 3; k++) if (g[k]) want.push_back(4'(FN_CNT_IN + k));
		foreach (want[k]) begin
			for (int p = 0; p < 8; p++) begin
				if (!used[p]) begin
					fn[p] = want[k];
					used[p] = 1'b1;
					break;
				end
			end
		end
	endfunction
	task automatic trial(input logic [7:0] om, input logic [7:0] im);
		logic [3:0] fn [8];
		logic [7:0] eoe, epu, lvl, eout;
		logic [5:0] ein;
		logic v, pp, x;
		wr(ADDR_ROUTE, rt);
		wr(ADDR_GLOBAL, gc);
		wr(ADDR_SKIP, sk);
		wr(ADDR_OUT_MODE, om);
		wr(ADDR_IN_MODE, im);
		wr(ADDR_PORT_DATA, lat);
		// pin to peripheral input runs through three flops
		repeat (6) @(posedge sys_clk);
		#1 place(rt, gc, sk, fn);
		x = gc[GC_XBAR_EN];
		ein = 6'h3F;
		for (int p = 0; p < 8; p++) begin
			if (fn[p] == FN_NONE) v = lat[p];
			else if (fn[p] == FN_SER_TX) v = src[8];
			else if (fn[p] >= FN_TW_DATA && fn[p] <= FN_CLK_OUT) v = src[10 - fn[p]];
			else if (fn[p] >= FN_COUNTER_MODULE0_LINE && fn[p] <= FN_CEX2) v = src[fn[p] - FN_COUNTER_MODULE0_LINE];
			else v = 1'b1;
			eout[p] = x ? v : lat[p];
			pp = om[p] && !(fn[p] == FN_TW_DATA || fn[p] == FN_TW_CLK);
			eoe[p] = x && im[p] && (pp || !v);
			epu[p] = im[p] && !gc[GC_PULLUP_DIS] && !(x && (pp || !v));
			lvl[p] = eoe[p] ? v : ext_lvl[p];
			if (x && fn[p] >= FN_SER_RX && fn[p] <= FN_TW_CLK)
				ein[fn[p] - FN_SER_RX] = lvl[p] | !im[p];
			if (x && fn[p] >= FN_CNT_IN) ein[fn[p] - FN_CNT_IN + 3] = lvl[p] | !im[p];
		end
		check("pin_oe", pin_oe, eoe);
		check("pin_out", pin_out, eout);
		check("pin_analog", pin_analog, ~im);
		check("pin_pullup_en", pin_pullup_en, epu);
		check("peripheral inputs", {2'b00, to_p}, {2'b00, ein});
		rd(ADDR_PORT_DATA, 1'b0);
		check("port read", d, lvl | ~im);
		rd(ADDR_PORT_DATA, 1'b1);
		check("port rmw read", d, lat);
	endtask
	initial begin
		repeat (20) @(posedge sys_clk);
		#1 arst_n = 1'b1;
		for (int k = 0; k < 7; k++) begin
			rd(ra[k], 1'b0);
			check("reset value", d, rv[k]);
			check("hit", {7'h0, h}, {7'h0, k < 6});
			if (k > 0) wr(ra[k], 8'hFF);
			rd(ra[k], 1'b0);
			if (k > 0) check("written value", d, wv[k]);
		end
		for (int k = 0; k < 80; k++) begin
			src = 9'($random(seed));
			ext_lvl = 8'($random(seed));
			rt = k < 4 ? {2'(k), 6'h3F} : 8'($random(seed));
			gc = 8'($random(seed)) | (k % 4 != 0 ? 8'h40 : 8'h00);
			sk = k < 8 ? 8'h44 * k[0] : 8'($random(seed)) & 8'h7F & ~{2'b0, rt[1:0], 4'h0};
			lat = 8'($random(seed));
			trial(8'($random(seed)), 8'($random(seed)) | ~sk | 8'h80);
		end
		for (int i = 0; i < 8; i++) begin
			lat[i] = 1'($random(seed));
			bwr(3'(i), lat[i]);
		end
		rd(ADDR_PORT_DATA, 1'b1);
		check("bit writes", d, lat);
		tally_and_finish();
	end
	// run needs about 2000 cycles; cut off well beyond that
	initial begin
		#200000;
		error_cnt++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
